//--- testbench/lac_regs_monitor.sv
// Checker of the logic array control bank, bound to lac_regs.
// Assumes only the bank's ports; shadows the writable registers itself.
`timescale 1ns/100ps
module lac_regs_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [lac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lac_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [lac_pkg::DATA_W-1:0] reg_rdata,
  input wire logic int_a,
  input wire logic int_b,
  input wire logic int_c,
  input wire logic int_d,
  input wire logic conv_start,
  input wire logic config_locked
);
  import lac_pkg::*;
  localparam logic [31:0] RW_ADR [5] = '{OFS_BLOCK_CLOCK_SELECT,
    OFS_IRQ_ROUTE_LOW_BLOCKS, OFS_IRQ_ROUTE_HIGH_BLOCKS,
    OFS_CONVERTER_TRIGGER_CONFIG, OFS_SOFT_INPUT_LOW_BLOCKS};
  localparam logic [15:0] RW_MSK [5] = '{CLK_SEL_MASK, IRQ_ROUTE_MASK,
    IRQ_ROUTE_MASK, CONV_MASK, SOFT_INPUT_MASK};
  logic [15:0] sh [5];
  logic lk;
  logic [15:0] exp_rd;
  logic known;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lk <= 1'h0;
      for (int i = 0; i < 5; i++) sh[i] <= 16'h0000;
    end else if (reg_write) begin
      if (reg_addr == OFS_CONFIG_WRITE_LOCK && reg_wdata[0]) lk <= 1'h1;
      for (int i = 0; i < 5; i++)
        if (!lk && reg_addr == RW_ADR[i]) sh[i] <= reg_wdata[15:0] & RW_MSK[i];
    end
  end
  // Element outputs are not modelled, so their reads are not predicted
  always_comb begin
    exp_rd = 16'h0000;
    known = 1'h1;
    for (int i = 0; i < 5; i++)
      if (reg_addr == RW_ADR[i]) exp_rd = sh[i];
    if (reg_addr == OFS_CONFIG_WRITE_LOCK) exp_rd = {15'h0000, lk};
    if (reg_addr == OFS_ELEMENT_OUTPUT_LOW) known = 1'h0;
    if (reg_addr == OFS_ELEMENT_OUTPUT_HIGH) known = 1'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_value: assert property (reg_read && known |=>
    reg_rdata == {16'h0000, $past(exp_rd)})
    else $error("read data differs from the written value");
  a_read_idle: assert property (!reg_read |=> reg_rdata == '0)
    else $error("read data not zero outside the read answer");
  a_read_upper: assert property (reg_read |=>
    reg_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_lock_sticky: assert property (config_locked |=> config_locked)
    else $error("lock cleared without reset");
  a_lock_set: assert property (reg_write && reg_addr ==
    OFS_CONFIG_WRITE_LOCK && reg_wdata[0] |-> ##2 config_locked)
    else $error("lock not set two cycles after the write");
  a_int_a_gate: assert property (!sh[1][4] |=> !int_a)
    else $error("int_a high while disabled");
  a_int_b_gate: assert property (!sh[1][12] |=> !int_b)
    else $error("int_b high while disabled");
  a_int_c_gate: assert property (!sh[2][4] |=> !int_c)
    else $error("int_c high while disabled");
  a_int_d_gate: assert property (!sh[2][12] |=> !int_d)
    else $error("int_d high while disabled");
  a_conv_gate: assert property (!sh[3][5] |=> !conv_start)
    else $error("conv_start high while disabled");
endmodule : lac_regs_monitor

bind lac_regs lac_regs_monitor i_lac_regs_monitor (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .int_a(int_a), .int_b(int_b), .int_c(int_c), .int_d(int_d),
  .conv_start(conv_start), .config_locked(config_locked));

//--- testbench/lac_regs_tb.sv
// Self-checking bench of the logic array control bank.
// Assumes the source model drives the clock ticks; read results queued.
`timescale 1ns/100ps
module lac_regs_tb;
  import lac_pkg::*;
  localparam logic [31:0] ADR [8] = '{OFS_BLOCK_CLOCK_SELECT,
    OFS_IRQ_ROUTE_LOW_BLOCKS, OFS_IRQ_ROUTE_HIGH_BLOCKS,
    OFS_CONVERTER_TRIGGER_CONFIG, OFS_SOFT_INPUT_LOW_BLOCKS,
    OFS_ELEMENT_OUTPUT_LOW, OFS_ELEMENT_OUTPUT_HIGH, 32'h4000_5894};
  localparam logic [15:0] MSK [8] = '{16'h7777, 16'h1F1F, 16'h1F1F,
    16'h003F, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [6:0] SRC [8] = '{7'h40, 7'h20, 7'h10, 7'h00, 7'h08,
    7'h04, 7'h02, 7'h01};
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [31:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic [31:0] reg_rdata;
  logic [6:0] fire = 7'h00;
  lac_ticks_t ticks;
  lac_elem_cfg_t [N_ELEM-1:0] elem_cfg = '0;
  logic [15:0] gpio_in = 16'h0000;
  logic int_a, int_b, int_c, int_d, conv_start, config_locked;
  logic took = 1'h0;
  logic [31:0] exp_q [$];
  int miscompares = 0;
  int cmp_count = 0;
  logic [15:0] seed = 16'h0060;
  logic [15:0] r [5];
  logic [31:0] p;

  always #5 clk = ~clk;

  lac_src_model i_lac_src_model (.clk(clk), .reset_n(reset_n),
    .fire(fire), .ticks(ticks));
  lac_regs i_lac_regs (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .clk_ticks(ticks), .elem_cfg(elem_cfg),
    .gpio_in(gpio_in), .int_a(int_a), .int_b(int_b), .int_c(int_c),
    .int_d(int_d), .conv_start(conv_start), .config_locked(config_locked));

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  function automatic logic [15:0] roll();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : roll

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= {16'h0000, d};
    reg_write <= 1'h1;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    exp_q.push_back({16'h0000, e});
    @(posedge clk);
    reg_read <= 1'h0;
  endtask : rd

  task automatic set_cfg(input logic [31:0] m, input logic [3:0] l,
                         input logic b);
    @(posedge clk);
    for (int i = 0; i < N_ELEM; i++) begin
      elem_cfg[i] <= '{2'h0, 2'h0, 1'h0, 1'h0, m[i] ? l : 4'h0, b};
    end
  endtask : set_cfg

  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 7'h00;
    repeat (3) @(posedge clk);
  endtask : pulse

  // Read answers are compared in the cycle where they stand
  always @(posedge clk) took <= reg_read;
  always @(negedge clk) begin
    if (took) begin
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      rd(ADR[i], 16'h0000);
      wr(ADR[i], 16'hFFFF);
      rd(ADR[i], MSK[i]);
    end
    // Constant element outputs routed to interrupts and converter
    for (int k = 0; k < 16; k++) begin
      for (int j = 0; j < 5; j++) r[j] = roll();
      p = {r[1], r[0]};
      set_cfg(p, 4'hF, 1'h1);
      gpio_in <= r[4];
      wr(OFS_IRQ_ROUTE_LOW_BLOCKS, r[2]);
      wr(OFS_IRQ_ROUTE_HIGH_BLOCKS, r[3]);
      wr(OFS_CONVERTER_TRIGGER_CONFIG, r[4]);
      rd(OFS_ELEMENT_OUTPUT_LOW, r[0]);
      rd(OFS_ELEMENT_OUTPUT_HIGH, r[1]);
      @(negedge clk);
      chk("int_a", int_a, r[2][4] & p[r[2][3:0]]);
      chk("int_b", int_b, r[2][12] & p[r[2][11:8]]);
      chk("int_c", int_c, r[3][4] & p[16 + r[3][3:0]]);
      chk("int_d", int_d, r[3][12] & p[16 + r[3][11:8]]);
      chk("conv_start", conv_start, r[4][5] & p[r[4][4:0]]);
    end
    set_cfg(32'h0000FFFF, 4'hC, 1'h1);
    r[0] = roll();
    wr(OFS_SOFT_INPUT_LOW_BLOCKS, r[0]);
    rd(OFS_SOFT_INPUT_LOW_BLOCKS, r[0]);
    rd(OFS_ELEMENT_OUTPUT_LOW, r[0]);
    // Element 1 takes element 0 through the even feedback path
    @(posedge clk);
    elem_cfg[1].input_a_select <= 1'h1;
    rd(OFS_ELEMENT_OUTPUT_LOW, {r[0][15:2], r[0][0], r[0][0]});
    // Flip-flop outputs follow only the selected block clock source
    set_cfg(32'h0000FFFF, 4'hC, 1'h0);
    wr(OFS_BLOCK_CLOCK_SELECT, 16'h3333);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_BLOCK_CLOCK_SELECT, {4{1'h0, c[2:0]}});
      wr(OFS_SOFT_INPUT_LOW_BLOCKS, ~r[0]);
      if (c != 3) begin
        pulse(~SRC[c]);
        rd(OFS_ELEMENT_OUTPUT_LOW, r[0]);
        pulse(SRC[c]);
      end
      r[0] = ~r[0];
      rd(OFS_ELEMENT_OUTPUT_LOW, r[0]);
    end
    rd(OFS_CONFIG_WRITE_LOCK, 16'h0000);
    wr(OFS_CONFIG_WRITE_LOCK, 16'hFFFE);
    rd(OFS_CONFIG_WRITE_LOCK, 16'h0000);
    wr(OFS_CONFIG_WRITE_LOCK, 16'hFFFF);
    wr(OFS_CONFIG_WRITE_LOCK, 16'h0000);
    rd(OFS_CONFIG_WRITE_LOCK, 16'h0001);
    chk("config_locked", config_locked, 32'h1);
    wr(OFS_SOFT_INPUT_LOW_BLOCKS, ~r[0]);
    wr(OFS_BLOCK_CLOCK_SELECT, 16'h0000);
    rd(OFS_SOFT_INPUT_LOW_BLOCKS, r[0]);
    rd(OFS_BLOCK_CLOCK_SELECT, 16'h7777);
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    @(negedge clk);
    chk("config_locked", config_locked, 32'h0);
    rd(OFS_CONFIG_WRITE_LOCK, 16'h0000);
    rd(OFS_SOFT_INPUT_LOW_BLOCKS, 16'h0000);
    wr(OFS_SOFT_INPUT_LOW_BLOCKS, r[1]);
    rd(OFS_SOFT_INPUT_LOW_BLOCKS, r[1]);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : lac_regs_tb

//--- testbench/lac_src_model.sv
// Far-side model of the block clock sources as one-cycle tick pulses.
// Assumes requests on fire change just after rising clk edges.
`timescale 1ns/100ps
module lac_src_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [6:0] fire,
  output lac_pkg::lac_ticks_t ticks
);
  import lac_pkg::*;
  // A requested source pulses once, one cycle after the request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ticks <= '0;
    end else begin
      ticks <= fire;
    end
  end
endmodule : lac_src_model

//--- verilog/lac_clk_pick.sv
// Picks one block's clock enable from the source pulses.
// Assumes all source pulses are synchronous one-cycle enables on clk.
`timescale 1ns/100ps
module lac_clk_pick (
  input wire lac_pkg::lac_clk_code_t code,
  input wire lac_pkg::lac_ticks_t ticks,
  output logic tick
);
  import lac_pkg::*;

  always_comb begin
    unique case (code)
      CS_GPIO_A: tick = ticks.gpio_a; // R2
      CS_GPIO_B: tick = ticks.gpio_b; // R2
      CS_GPIO_C: tick = ticks.gpio_c; // R2
      CS_BUS_CLK: tick = 1'b1; // R3
      CS_MAIN_16M: tick = ticks.main_16m_oscillator; // R3
      CS_TIMER0: tick = ticks.timer0; // R4
      CS_TIMER2: tick = ticks.timer2; // R4
      CS_LOW_32K: tick = ticks.low_32k_oscillator; // R3
    endcase
  end
endmodule : lac_clk_pick

//--- verilog/lac_element.sv
// One logic array element: input muxes, 2-input lookup table, flip-flop.
// Assumes feedback and inputs are synchronous to clk; tick is the block clock.
`timescale 1ns/100ps
module lac_element #(
  parameter bit HAS_GPIO = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire lac_pkg::lac_elem_cfg_t cfg,
  input wire logic soft_in,
  input wire logic even_fb,
  input wire logic odd_fb,
  input wire logic gpio_in,
  output logic out
);
  import lac_pkg::*;

  logic in_a;
  logic in_b;
  logic comb;
  logic state;

  assign in_a = cfg.input_a_select ? even_fb : soft_in; // R15
  assign in_b = (HAS_GPIO && cfg.input_b_gpio) ? gpio_in : odd_fb;
  assign comb = cfg.lut[{in_a, in_b}];

  // Flip-flop advances only on the block's selected clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= 1'b0;
    end else if (tick) begin
      state <= comb; // R16
    end
  end

  // Bypass gives a combinational path; feedback through it may loop
  assign out = cfg.ff_bypass_select ? comb : state; // R16
endmodule : lac_element

//--- verilog/lac_pkg.sv
// Constants, field layouts and carrier types of the logic array control bank.
// Assumes a 32-bit byte address and a 100 MHz system clock.
package lac_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int N_ELEM = 32;
  localparam int N_BLOCK = 4;
  localparam int BLOCK_SIZE = 8;
  localparam int HIGH_ELEM_BASE = 16;

  localparam logic [31:0] OFS_BLOCK_CLOCK_SELECT = 32'h4000_5880;
  localparam logic [31:0] OFS_IRQ_ROUTE_LOW_BLOCKS = 32'h4000_5884;
  localparam logic [31:0] OFS_IRQ_ROUTE_HIGH_BLOCKS = 32'h4000_5888;
  localparam logic [31:0] OFS_CONVERTER_TRIGGER_CONFIG = 32'h4000_588C;
  localparam logic [31:0] OFS_SOFT_INPUT_LOW_BLOCKS = 32'h4000_5890;
  localparam logic [31:0] OFS_ELEMENT_OUTPUT_LOW = 32'h4000_5898;
  localparam logic [31:0] OFS_ELEMENT_OUTPUT_HIGH = 32'h4000_589C;
  localparam logic [31:0] OFS_CONFIG_WRITE_LOCK = 32'h4000_58A0;

  localparam int CLK_SEL_W = 3;
  localparam int GRP_LSB_STEP = 4;
  localparam int INT_SRC_W = 4;
  localparam int INT_FIRST_SRC_LSB = 0;
  localparam int INT_FIRST_EN_BIT = 4;
  localparam int INT_SECOND_SRC_LSB = 8;
  localparam int INT_SECOND_EN_BIT = 12;
  localparam int CONV_SRC_LSB = 0;
  localparam int CONV_SRC_W = 5;
  localparam int CONV_EN_BIT = 5;
  localparam int LOCK_BIT = 0;

  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] CLK_SEL_MASK = 16'h7777;
  localparam logic [15:0] IRQ_ROUTE_MASK = 16'h1F1F;
  localparam logic [15:0] CONV_MASK = 16'h003F;
  localparam logic [15:0] SOFT_INPUT_MASK = 16'hFFFF;

  typedef enum logic [2:0] {
    CS_GPIO_A = 3'b000,
    CS_GPIO_B = 3'b001,
    CS_GPIO_C = 3'b010,
    CS_BUS_CLK = 3'b011,
    CS_MAIN_16M = 3'b100,
    CS_TIMER0 = 3'b101,
    CS_TIMER2 = 3'b110,
    CS_LOW_32K = 3'b111
  } lac_clk_code_t;

  // One-cycle enable pulses standing for each block clock source but the bus clock
  typedef struct packed {
    logic gpio_a;
    logic gpio_b;
    logic gpio_c;
    logic main_16m_oscillator;
    logic timer0;
    logic timer2;
    logic low_32k_oscillator;
  } lac_ticks_t;

  // Per-element configuration held outside this bank
  typedef struct packed {
    logic [1:0] even_fb_sel;
    logic [1:0] odd_fb_sel;
    logic input_a_select;
    logic input_b_gpio;
    logic [3:0] lut;
    logic ff_bypass_select;
  } lac_elem_cfg_t;
endpackage : lac_pkg

//--- verilog/lac_regs.sv
// Control and status register bank of the 32-element logic array.
// Assumes a plain register port with one-cycle strobes, read data one cycle
// later, clock sources as one-cycle enable pulses synchronous to clk.
`timescale 1ns/100ps

// Contract
// [R1] Four 3-bit block clock selectors at [14:12], [10:8], [6:4], [2:0].
// [R2] Codes 000, 001, 010 pick the three external pin clocks.
// [R3] 011 bus clock, 100 16 MHz oscillator, 111 32 kHz oscillator.
// [R4] 101 picks general timer 0 output, 110 general timer 2 output.
// [R5] First and second interrupts pass only while bits 4 and 12 set.
// [R6] Low-block interrupt source field selects element equal to its value.
// [R7] High-block interrupt source field selects element value plus 16.
// [R8] Third and fourth interrupts gated by bits 4 and 12 of high register.
// [R9] Converter start request driven only while enable bit 5 is set.
// [R10] Soft input register bit n feeds element n, readable and writable.
// [R11] First output register reads current outputs of elements 0 to 15.
// [R12] Second output register reads outputs of elements 16 to 31.
// [R13] Lock bit set by writing one, stays until reset, zero ignored.
// [R14] While locked, writes to configuration registers are ignored.
// [R15] Element input A is soft input or even feedback, by select bit.
// [R16] Element output is flip-flop or bypassed result, by select bit.
// [R17] 5-bit converter source field names the driving element directly.
// [R18] Writable fields reset to zero; reserved bits read zero, ignore writes.
module lac_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [lac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lac_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [lac_pkg::DATA_W-1:0] reg_rdata,
  input wire lac_pkg::lac_ticks_t clk_ticks,
  input wire lac_pkg::lac_elem_cfg_t [lac_pkg::N_ELEM-1:0] elem_cfg,
  input wire logic [lac_pkg::HIGH_ELEM_BASE-1:0] gpio_in,
  output logic int_a,
  output logic int_b,
  output logic int_c,
  output logic int_d,
  output logic conv_start,
  output logic config_locked
);
  import lac_pkg::*;

  // Register storage
  logic [REG_W-1:0] block_clock_select;
  logic [REG_W-1:0] irq_route_low_blocks;
  logic [REG_W-1:0] irq_route_high_blocks;
  logic [REG_W-1:0] converter_trigger_config;
  logic [REG_W-1:0] soft_input_low_blocks;
  logic lock;

  // Address decode
  logic hit_clk;
  logic hit_irq_lo;
  logic hit_irq_hi;
  logic hit_conv;
  logic hit_din;
  logic hit_dout_lo;
  logic hit_dout_hi;
  logic hit_lock;
  logic cfg_write;
  logic wr_clk;
  logic wr_irq_lo;
  logic wr_irq_hi;
  logic wr_conv;
  logic wr_din;
  logic set_lock;
  logic [REG_W-1:0] wdata16;

  // Field views
  lac_clk_code_t grp_clk_sel [N_BLOCK];
  logic [INT_SRC_W-1:0] int_a_source;
  logic [INT_SRC_W-1:0] int_b_source;
  logic [INT_SRC_W-1:0] int_c_source;
  logic [INT_SRC_W-1:0] int_d_source;
  logic int_a_enable;
  logic int_b_enable;
  logic int_c_enable;
  logic int_d_enable;
  logic [CONV_SRC_W-1:0] conv_trigger_source;
  logic conv_trigger_enable;
  logic [$clog2(N_ELEM)-1:0] int_a_elem;
  logic [$clog2(N_ELEM)-1:0] int_b_elem;
  logic [$clog2(N_ELEM)-1:0] int_c_elem;
  logic [$clog2(N_ELEM)-1:0] int_d_elem;
  logic [$clog2(N_ELEM)-1:0] conv_elem;

  // Array signals
  logic [N_BLOCK-1:0] block_tick;
  logic [N_ELEM-1:0] elem_out;
  logic [N_ELEM-1:0] soft_in;
  logic [N_ELEM-1:0] elem_gpio;
  logic [REG_W-1:0] dout_low;
  logic [REG_W-1:0] dout_high;
  logic [REG_W-1:0] lock_view;

  logic [REG_W-1:0] next_rdata;
  logic next_int_a;
  logic next_int_b;
  logic next_int_c;
  logic next_int_d;
  logic next_conv_start;

  assign hit_clk = (reg_addr == OFS_BLOCK_CLOCK_SELECT);
  assign hit_irq_lo = (reg_addr == OFS_IRQ_ROUTE_LOW_BLOCKS);
  assign hit_irq_hi = (reg_addr == OFS_IRQ_ROUTE_HIGH_BLOCKS);
  assign hit_conv = (reg_addr == OFS_CONVERTER_TRIGGER_CONFIG);
  assign hit_din = (reg_addr == OFS_SOFT_INPUT_LOW_BLOCKS);
  assign hit_dout_lo = (reg_addr == OFS_ELEMENT_OUTPUT_LOW);
  assign hit_dout_hi = (reg_addr == OFS_ELEMENT_OUTPUT_HIGH);
  assign hit_lock = (reg_addr == OFS_CONFIG_WRITE_LOCK);

  // Configuration writes pass only while the bank is unlocked
  assign cfg_write = reg_write && !lock; // R14

  // One write enable per register; reserved bits never reach storage
  assign wdata16 = reg_wdata[REG_W-1:0];
  assign wr_clk = cfg_write && hit_clk;
  assign wr_irq_lo = cfg_write && hit_irq_lo;
  assign wr_irq_hi = cfg_write && hit_irq_hi;
  assign wr_conv = cfg_write && hit_conv;
  assign wr_din = cfg_write && hit_din;
  // Lock writes bypass the lock itself, so it can only ever be set
  assign set_lock = reg_write && hit_lock && reg_wdata[LOCK_BIT]; // R13

  // Field extraction
  always_comb begin
    for (int b = 0; b < N_BLOCK; b++) begin
      grp_clk_sel[b] = lac_clk_code_t'(
        block_clock_select[b*GRP_LSB_STEP +: CLK_SEL_W]); // R1
    end
  end

  assign int_a_source =
    irq_route_low_blocks[INT_FIRST_SRC_LSB +: INT_SRC_W];
  assign int_b_source =
    irq_route_low_blocks[INT_SECOND_SRC_LSB +: INT_SRC_W];
  assign int_c_source =
    irq_route_high_blocks[INT_FIRST_SRC_LSB +: INT_SRC_W];
  assign int_d_source =
    irq_route_high_blocks[INT_SECOND_SRC_LSB +: INT_SRC_W];
  assign int_a_enable = irq_route_low_blocks[INT_FIRST_EN_BIT];
  assign int_b_enable = irq_route_low_blocks[INT_SECOND_EN_BIT];
  assign int_c_enable = irq_route_high_blocks[INT_FIRST_EN_BIT];
  assign int_d_enable = irq_route_high_blocks[INT_SECOND_EN_BIT];
  assign conv_trigger_source =
    converter_trigger_config[CONV_SRC_LSB +: CONV_SRC_W];
  assign conv_trigger_enable = converter_trigger_config[CONV_EN_BIT];

  // Element numbers behind each routed source
  assign int_a_elem = {1'b0, int_a_source}; // R6
  assign int_b_elem = {1'b0, int_b_source}; // R6
  assign int_c_elem = {1'b1, int_c_source}; // R7
  assign int_d_elem = {1'b1, int_d_source}; // R7
  assign conv_elem = conv_trigger_source; // R17

  // Block clock selection register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      block_clock_select <= RESET_VALUE; // R18
    end else if (wr_clk) begin
      block_clock_select <= wdata16 & CLK_SEL_MASK; // R1 R18
    end
  end

  // Interrupt routing for blocks zero and one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_route_low_blocks <= RESET_VALUE;
    end else if (wr_irq_lo) begin
      irq_route_low_blocks <= wdata16 & IRQ_ROUTE_MASK; // R18
    end
  end

  // Interrupt routing for blocks two and three
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_route_high_blocks <= RESET_VALUE;
    end else if (wr_irq_hi) begin
      irq_route_high_blocks <= wdata16 & IRQ_ROUTE_MASK; // R18
    end
  end

  // Converter trigger configuration
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converter_trigger_config <= RESET_VALUE;
    end else if (wr_conv) begin
      converter_trigger_config <= wdata16 & CONV_MASK; // R18
    end
  end

  // Software data inputs of elements 0 to 15
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_input_low_blocks <= RESET_VALUE;
    end else if (wr_din) begin
      soft_input_low_blocks <= wdata16 & SOFT_INPUT_MASK; // R10
    end
  end

  // Lock only ever sets; a zero write leaves it as it is
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock <= 1'b0;
    end else if (set_lock) begin
      lock <= 1'b1; // R13
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_locked <= 1'b0;
    end else begin
      config_locked <= lock; // R14
    end
  end

  // Per-block clock enables
  for (genvar b = 0; b < N_BLOCK; b++) begin : g_clk
    lac_clk_pick u_pick (
      .code(grp_clk_sel[b]),
      .ticks(clk_ticks),
      .tick(block_tick[b])
    );
  end

  // Upper elements have no software or pin input
  assign soft_in = {{(N_ELEM-HIGH_ELEM_BASE){1'b0}},
    soft_input_low_blocks}; // R10
  assign elem_gpio = {{(N_ELEM-HIGH_ELEM_BASE){1'b0}}, gpio_in};

  // Elements with feedback inside their block of eight, bar the first element's even path at select 00
  for (genvar e = 0; e < N_ELEM; e++) begin : g_elem
    localparam int BASE = (e / BLOCK_SIZE) * BLOCK_SIZE;
    localparam int PREV = (BASE + N_ELEM - 1) % N_ELEM;
    logic even_fb;
    logic odd_fb;
    logic [4:0] even_idx;
    logic [4:0] odd_idx;

    always_comb begin
      even_idx = 5'(BASE) + {2'b00, elem_cfg[e].even_fb_sel, 1'b0};
      odd_idx = 5'(BASE) + {2'b00, elem_cfg[e].odd_fb_sel, 1'b1};
      // First element of a block at even select 00 takes the previous block's last output
      if ((e % BLOCK_SIZE == 0) && (elem_cfg[e].even_fb_sel == 2'b00)) begin
        even_fb = elem_out[PREV];
      end else begin
        even_fb = elem_out[even_idx];
      end
      odd_fb = elem_out[odd_idx];
    end

    lac_element #(
      .HAS_GPIO(e < HIGH_ELEM_BASE)
    ) u_elem (
      .clk(clk),
      .reset_n(reset_n),
      .tick(block_tick[e / BLOCK_SIZE]),
      .cfg(elem_cfg[e]),
      .soft_in(soft_in[e]), // R15
      .even_fb(even_fb),
      .odd_fb(odd_fb),
      .gpio_in(elem_gpio[e]),
      .out(elem_out[e]) // R16
    );
  end

  // Interrupt routing
  always_comb begin
    next_int_a = int_a_enable && elem_out[int_a_elem]; // R5 R6
    next_int_b = int_b_enable && elem_out[int_b_elem]; // R5 R6
    next_int_c = int_c_enable && elem_out[int_c_elem]; // R7 R8
    next_int_d = int_d_enable && elem_out[int_d_elem]; // R7 R8
  end

  // Routed interrupts, one flop each
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_a <= 1'b0;
    end else begin
      int_a <= next_int_a; // R5
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_b <= 1'b0;
    end else begin
      int_b <= next_int_b; // R5
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_c <= 1'b0;
    end else begin
      int_c <= next_int_c; // R8
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_d <= 1'b0;
    end else begin
      int_d <= next_int_d; // R8
    end
  end

  // Converter start request
  assign next_conv_start =
    conv_trigger_enable && elem_out[conv_elem]; // R9 R17

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= next_conv_start; // R9
    end
  end

  // Snapshots of element outputs and the lock as software sees them
  assign dout_low = elem_out[HIGH_ELEM_BASE-1:0]; // R11
  assign dout_high = elem_out[N_ELEM-1:HIGH_ELEM_BASE]; // R12
  assign lock_view = {{(REG_W-1){1'b0}}, lock}; // R18

  // Read mux; unmapped addresses return zero
  always_comb begin
    next_rdata = RESET_VALUE;
    if (hit_clk) begin
      next_rdata = block_clock_select;
    end else if (hit_irq_lo) begin
      next_rdata = irq_route_low_blocks;
    end else if (hit_irq_hi) begin
      next_rdata = irq_route_high_blocks;
    end else if (hit_conv) begin
      next_rdata = converter_trigger_config;
    end else if (hit_din) begin
      next_rdata = soft_input_low_blocks; // R10
    end else if (hit_dout_lo) begin
      next_rdata = dout_low; // R11
    end else if (hit_dout_hi) begin
      next_rdata = dout_high; // R12
    end else if (hit_lock) begin
      next_rdata = lock_view; // R18
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= {{(DATA_W-REG_W){1'b0}}, next_rdata};
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : lac_regs
